// ---- rtl/mzb_pkg.sv ----
package mzb_pkg;

	// Clock and bus timing
	localparam int CLK_HZ = 20_000_000;
	localparam int BUS_CLK_HZ = 8_000_000;
	localparam int SYNC_STAGES = 2;

	// Pin widths
	localparam int WADDR_W = 6;
	localparam int DATA_W = 16;
	localparam int EXT_ADDR_W = 16;
	localparam int USR_ADDR_W = WADDR_W + EXT_ADDR_W;
	localparam int SYNC_W = 1 + WADDR_W + DATA_W + 1 + 2 + 4;

	// Space layout, in 16-bit locations
	localparam int IO_WORDS = 64;
	localparam int ID_BYTES = 32;
	localparam int VEC_COUNT = 2;
	localparam int ID_ADDR_TOP = 5;
	localparam int ID_DATA_W = 8;

	// Transfer space codes on the user side
	localparam logic [1:0] SPACE_MEM = 2'h0;
	localparam logic [1:0] SPACE_IO = 2'h1;
	localparam logic [1:0] SPACE_ID = 2'h2;
	localparam logic [1:0] SPACE_VEC = 2'h3;

	// Longest wait, in bus cycles after the select cycle, per space for reads, and one value for all writes
	localparam logic [2:0] WAIT_MAX_MEM = 3'h4;
	localparam logic [2:0] WAIT_MAX_IO = 3'h2;
	localparam logic [2:0] WAIT_MAX_ID = 3'h1;
	localparam logic [2:0] WAIT_MAX_VEC = 3'h1;
	localparam logic [2:0] WAIT_MAX_WR = 3'h0;

	// Reset values
	localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
	localparam logic [USR_ADDR_W-1:0] ADDR_RST = 22'h0;

	typedef enum logic [3:0]
	{
		MZB_IDLE = 4'b0001,
		MZB_WAIT = 4'b0010,
		MZB_ACK = 4'b0100,
		MZB_DROP = 4'b1000
	} mzb_state_e;

endpackage

// ---- rtl/mzb_slave.sv ----
`timescale 1ns/100ps
`default_nettype none

module mzb_slave
	import mzb_pkg::*;
(
	// Clock, reset, enable
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	// Carrier bus pins
	input wire logic bus_clock,
	input wire logic [WADDR_W-1:0] word_address_lines,
	input wire logic [DATA_W-1:0] bidir_data_lines_in,
	output logic [DATA_W-1:0] bidir_data_lines_out,
	output logic bidir_data_lines_oe,
	input wire logic read_write_direction,
	input wire logic low_byte_select_n,
	input wire logic high_byte_select_n,
	input wire logic memory_space_select_n,
	input wire logic io_space_select_n,
	input wire logic vector_read_select_n,
	input wire logic identity_read_select_n,
	output logic ack_n,
	// User side requests
	output logic usr_req,
	output logic usr_we,
	output logic [1:0] usr_space,
	output logic [USR_ADDR_W-1:0] usr_addr,
	output logic [DATA_W-1:0] usr_wdata,
	output logic [1:0] usr_be,
	input wire logic [DATA_W-1:0] usr_rdata,
	input wire logic usr_rdy,
	// Interrupt blocking after reset
	input wire logic usr_irq_enable,
	output logic irq_blocked
);

	logic [SYNC_W-1:0] pins;
	logic [SYNC_W-1:0] sync1_reg;
	logic [SYNC_W-1:0] sync2_reg;
	logic bclk_d_reg;
	logic bus_edge;
	logic s_clk;
	logic [WADDR_W-1:0] s_addr;
	logic [DATA_W-1:0] s_data;
	logic s_rd;
	logic [1:0] s_be_n;
	logic s_mem;
	logic s_io;
	logic s_vec;
	logic s_id;
	logic any_sel;
	logic valid_sel;
	logic [1:0] sel_space;
	logic id_ok;
	mzb_state_e state_reg;
	logic [1:0] space_reg;
	logic rd_reg;
	logic [2:0] wait_cnt_reg;
	logic [2:0] wait_max;
	logic rdy_seen_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic first_ack_reg;

	assign pins = {bus_clock, word_address_lines, bidir_data_lines_in,
		read_write_direction, high_byte_select_n, low_byte_select_n,
		memory_space_select_n, io_space_select_n, vector_read_select_n,
		identity_read_select_n};

	// Two-stage synchroniser for every carrier pin
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sync1_reg <= '1;
			sync2_reg <= '1;
		end
		else if (ce)
		begin
			sync1_reg <= pins;
			sync2_reg <= sync1_reg;
		end
	end

	assign {s_clk, s_addr, s_data, s_rd, s_be_n, s_mem, s_io, s_vec, s_id} =
		sync2_reg;

	// Bus clock edge seen after synchronising
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			bclk_d_reg <= 1'b1;
		else if (ce)
			bclk_d_reg <= s_clk;
	end
	assign bus_edge = s_clk && !bclk_d_reg;

	// Selects are active low; only single-select patterns are decoded
	assign any_sel = !(s_mem && s_io && s_vec && s_id);
	always_comb
	begin
		sel_space = SPACE_MEM;
		valid_sel = 1'b0;
		case ({s_mem, s_io, s_vec, s_id})
			4'b0111:
			begin
				sel_space = SPACE_MEM;
				valid_sel = 1'b1;
			end
			4'b1011:
			begin
				sel_space = SPACE_IO;
				valid_sel = 1'b1;
			end
			4'b1101:
			begin
				sel_space = SPACE_VEC;
				valid_sel = s_rd;
			end
			4'b1110:
			begin
				sel_space = SPACE_ID;
				valid_sel = s_rd;
			end
			default:
			begin
				sel_space = SPACE_MEM;
				valid_sel = 1'b0;
			end
		endcase
	end

	// Identity space answers only with the top address bit clear
	assign id_ok = (sel_space != SPACE_ID) || !s_addr[ID_ADDR_TOP];

	always_comb
	begin
		case (space_reg)
			SPACE_MEM:
				wait_max = WAIT_MAX_MEM;
			SPACE_IO:
				wait_max = WAIT_MAX_IO;
			SPACE_ID:
				wait_max = WAIT_MAX_ID;
			default:
				wait_max = WAIT_MAX_VEC;
		endcase
		if (!rd_reg)
			wait_max = WAIT_MAX_WR;
	end

	// Transfer sequencing, one step per bus clock edge
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_reg <= MZB_IDLE;
			space_reg <= SPACE_MEM;
			rd_reg <= 1'b0;
			wait_cnt_reg <= 3'h0;
			first_ack_reg <= 1'b0;
		end
		else if (ce && bus_edge)
		begin
			case (state_reg)
				MZB_IDLE:
				begin
					if (any_sel && valid_sel && id_ok)
					begin
						state_reg <= MZB_WAIT;
						space_reg <= sel_space;
						rd_reg <= s_rd;
						wait_cnt_reg <= 3'h0;
					end
					else if (any_sel)
						state_reg <= MZB_DROP;
				end
				MZB_WAIT:
				begin
					if (!rd_reg || rdy_seen_reg || usr_rdy ||
						wait_cnt_reg >= wait_max)
					begin
						state_reg <= MZB_ACK;
						first_ack_reg <= 1'b1;
					end
					else
						wait_cnt_reg <= wait_cnt_reg + 3'h1;
				end
				MZB_ACK:
				begin
					first_ack_reg <= 1'b0;
					if (!any_sel)
						state_reg <= MZB_IDLE;
				end
				MZB_DROP:
				begin
					if (!any_sel)
						state_reg <= MZB_IDLE;
				end
				default:
					state_reg <= MZB_IDLE;
			endcase
		end
	end

	// Address capture; memory upper bits ride the data lines
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			usr_addr <= ADDR_RST;
			usr_space <= SPACE_MEM;
			usr_be <= 2'h0;
		end
		else if (ce && bus_edge && state_reg == MZB_IDLE && any_sel &&
			valid_sel && id_ok)
		begin
			usr_space <= sel_space;
			usr_be <= ~s_be_n;
			case (sel_space)
				SPACE_MEM:
					usr_addr <= {s_data, s_addr};
				SPACE_IO:
					usr_addr <= {16'h0000, s_addr};
				SPACE_ID:
					usr_addr <= {17'h0, s_addr[ID_ADDR_TOP-1:0]};
				default:
					usr_addr <= {21'h0, s_addr[0]};
			endcase
		end
	end

	// Request strobes: reads at select, writes at first acknowledge
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			usr_req <= 1'b0;
			usr_we <= 1'b0;
			usr_wdata <= DATA_RST;
		end
		else if (ce)
		begin
			usr_req <= 1'b0;
			if (bus_edge && state_reg == MZB_IDLE && any_sel &&
				valid_sel && id_ok && s_rd)
			begin
				usr_req <= 1'b1;
				usr_we <= 1'b0;
			end
			else if (bus_edge && state_reg == MZB_ACK && first_ack_reg &&
				!rd_reg)
			begin
				usr_req <= 1'b1;
				usr_we <= 1'b1;
				usr_wdata <= s_data;
			end
		end
	end

	// Read data held from the user's ready strobe
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rdy_seen_reg <= 1'b0;
			rdata_reg <= DATA_RST;
		end
		else if (ce)
		begin
			if (state_reg == MZB_IDLE)
				rdy_seen_reg <= 1'b0;
			else if (usr_rdy && state_reg == MZB_WAIT && !rdy_seen_reg)
			begin
				rdy_seen_reg <= 1'b1;
				if (space_reg == SPACE_ID || space_reg == SPACE_VEC)
					rdata_reg <= {8'h00, usr_rdata[ID_DATA_W-1:0]};
				else
					rdata_reg <= usr_rdata;
			end
		end
	end

	// Acknowledge and data drivers follow the state
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ack_n <= 1'b1;
			bidir_data_lines_oe <= 1'b0;
			bidir_data_lines_out <= DATA_RST;
		end
		else if (ce)
		begin
			ack_n <= !(state_reg == MZB_ACK);
			bidir_data_lines_oe <= state_reg == MZB_ACK && rd_reg;
			bidir_data_lines_out <= rdata_reg;
		end
	end

	// Interrupt requests stay blocked from reset until software enables
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			irq_blocked <= 1'b1;
		else if (ce && usr_irq_enable)
			irq_blocked <= 1'b0;
	end

endmodule
`default_nettype wire

// ---- dv/mzb_slave_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
module mzb_chk
	import mzb_pkg::*;
(
	// Watched ports
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ack_n,
	input wire logic bidir_data_lines_oe,
	input wire logic [DATA_W-1:0] bidir_data_lines_out,
	input wire logic memory_space_select_n,
	input wire logic io_space_select_n,
	input wire logic vector_read_select_n,
	input wire logic identity_read_select_n,
	input wire logic usr_req,
	input wire logic usr_we,
	input wire logic [1:0] usr_space,
	input wire logic usr_irq_enable,
	input wire logic irq_blocked
);
	logic idle;
	assign idle = memory_space_select_n & io_space_select_n
		& vector_read_select_n & identity_read_select_n;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	oe_in_ack_a: assert property (bidir_data_lines_oe |-> !ack_n)
		else $error("data driven outside ack");
	idle_no_ack_a: assert property (idle [*8] |=> ack_n)
		else $error("ack held with selects idle");
	ack_in_sel_a: assert property ($fell(ack_n) |-> !idle)
		else $error("ack without select");
	req_pulse_a: assert property (usr_req |=> !usr_req)
		else $error("request wider than a cycle");
	wr_req_ack_a: assert property (usr_req && usr_we |-> !ack_n)
		else $error("write taken outside ack");
	rd_wait_a: assert property (
		usr_req && !usr_we |-> ack_n ##[1:40] !ack_n)
		else $error("read ack late");
	blk_hold_a: assert property (
		irq_blocked && !usr_irq_enable |=> irq_blocked)
		else $error("block lifted unasked");
	id_byte_a: assert property (
		bidir_data_lines_oe && usr_space[1]
		|-> bidir_data_lines_out[15:8] == 8'h00)
		else $error("upper byte not zero");
endmodule
bind mzb_slave mzb_chk i_chk (
	.clk(clk),
	.arst_n(arst_n),
	.ack_n(ack_n),
	.bidir_data_lines_oe(bidir_data_lines_oe),
	.bidir_data_lines_out(bidir_data_lines_out),
	.memory_space_select_n(memory_space_select_n),
	.io_space_select_n(io_space_select_n),
	.vector_read_select_n(vector_read_select_n),
	.identity_read_select_n(identity_read_select_n),
	.usr_req(usr_req),
	.usr_we(usr_we),
	.usr_space(usr_space),
	.usr_irq_enable(usr_irq_enable),
	.irq_blocked(irq_blocked)
);
`default_nettype wire

// ---- dv/mzb_carrier.sv ----
`timescale 1ns/100ps
`default_nettype none
module mzb_carrier
	import mzb_pkg::*;
(
	// Pins toward the module
	output logic bus_clock,
	output logic [WADDR_W-1:0] adr,
	output logic dir,
	output logic [1:0] bs_n,
	output logic [3:0] sel_n,
	output logic drv_en,
	output logic [DATA_W-1:0] drv_d,
	input wire logic [DATA_W-1:0] data,
	input wire logic ack_n,
	// Read result
	output logic rd_done,
	output logic [DATA_W-1:0] rd_q
);
	initial
	begin
		{adr, dir, bs_n, drv_en, drv_d, rd_done, rd_q} = '0;
		sel_n = 4'hF;
		bus_clock = 1'b0;
		forever #62.5 bus_clock = ~bus_clock;
	end
	task automatic xfer(input logic [1:0] s, input logic r,
		input logic [21:0] a, input logic [15:0] d, input logic [1:0] b,
		output logic ok);
		int n;
		@(posedge bus_clock);
		sel_n[s] <= 1'b0;
		adr <= a[5:0];
		dir <= r;
		bs_n <= b;
		drv_en <= s == SPACE_MEM || !r;
		drv_d <= s == SPACE_MEM ? a[21:6] : d;
		@(posedge bus_clock);
		drv_en <= !r;
		drv_d <= d;
		n = 0;
		while (ack_n !== 1'b0 && n < 12)
		begin
			@(posedge bus_clock);
			n++;
		end
		ok = ack_n === 1'b0;
		rd_done <= ok && r;
		rd_q <= data;
		// Drop selects; idle pins go to garbage
		sel_n <= 4'hF;
		adr <= ~adr;
		dir <= ~dir;
		drv_en <= 1'b0;
		@(posedge bus_clock);
		rd_done <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb
	import mzb_pkg::*;
;
	logic clk, arst_n, irq_en, rdy, oe, ack_n, req, we, blk, bck, dir;
	logic drv_en, rd_done, ok;
	logic [5:0] adr;
	logic [1:0] bs_n, sp, be;
	logic [3:0] sel_n;
	logic [15:0] dout, drv_d, data, wd, rdat, rd_q;
	logic [21:0] ua;
	logic [42:0] q_req[$];
	logic [15:0] q_rd[$];
	int n_mismatch, samples_checked, i;
	integer seed;
	assign data = oe ? dout : drv_en ? drv_d : 16'hFFFF;
	mzb_slave i_dut (.clk(clk), .arst_n(arst_n), .ce(1'b1), .bus_clock(bck),
		.word_address_lines(adr), .bidir_data_lines_in(data),
		.bidir_data_lines_out(dout), .bidir_data_lines_oe(oe),
		.read_write_direction(dir), .low_byte_select_n(bs_n[0]),
		.high_byte_select_n(bs_n[1]), .memory_space_select_n(sel_n[0]),
		.io_space_select_n(sel_n[1]), .identity_read_select_n(sel_n[2]),
		.vector_read_select_n(sel_n[3]), .ack_n(ack_n), .usr_req(req),
		.usr_we(we), .usr_space(sp), .usr_addr(ua), .usr_wdata(wd),
		.usr_be(be), .usr_rdata(rdat), .usr_rdy(rdy),
		.usr_irq_enable(irq_en), .irq_blocked(blk));
	mzb_carrier i_car (.bus_clock(bck), .adr(adr), .dir(dir), .bs_n(bs_n),
		.sel_n(sel_n), .drv_en(drv_en), .drv_d(drv_d), .data(data),
		.ack_n(ack_n), .rd_done(rd_done), .rd_q(rd_q));
	task automatic cmp(input logic [42:0] e, input logic [42:0] a);
		samples_checked++;
		if (a !== e)
		begin
			n_mismatch++;
			$display("mismatch at %0t: expected %h got %h", $time, e, a);
		end
	endtask
	task automatic tally_and_finish;
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic run(input logic [1:0] s, input logic r,
		input logic [21:0] a, input logic [15:0] d, input logic [1:0] b);
		logic [21:0] ea;
		logic good;
		if (b == 2'b11)
			b = 2'b00;
		good = (r || s < SPACE_ID) && !(s == SPACE_ID && a[5]);
		ea = s == SPACE_MEM ? a : s == SPACE_IO ? {16'h0, a[5:0]}
			: s == SPACE_ID ? {17'h0, a[4:0]} : {21'h0, a[0]};
		if (good)
			q_req.push_back({~r, s, ea, r ? 16'h0 : d, ~b});
		if (good && r)
			q_rd.push_back({s[1] ? 8'h00 : ea[7:0], ~ea[7:0]});
		i_car.xfer(s, r, a, d, b, ok);
		cmp({42'h0, good}, {42'h0, ok});
		$display("test space %0d read %0d done", s, r);
	endtask
	always @(negedge clk)
		rdat <= {ua[7:0], ~ua[7:0]};
	always @(negedge clk)
		if (arst_n && req === 1'b1)
			cmp(q_req.pop_front(), {we, sp, ua, we ? wd : 16'h0, be});
	always @(posedge bck)
		if (rd_done === 1'b1)
			cmp({27'h0, q_rd.pop_front()}, {27'h0, rd_q});
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial
	begin
		#400us;
		n_mismatch++;
		tally_and_finish();
	end
	initial
	begin
		{n_mismatch, samples_checked} = '0;
		seed = 17599;
		{arst_n, irq_en} = '0;
		rdy = 1'b1;
		repeat (3) @(negedge clk);
		arst_n = 1'b1;
		cmp(43'h1, {42'h0, blk});
		@(negedge clk);
		irq_en = 1'b1;
		@(negedge clk);
		irq_en = 1'b0;
		cmp(43'h0, {42'h0, blk});
		for (i = 0; i < 32; i++)
			run(i[1:0], i[2], 22'($random(seed)), 16'($random(seed)),
				2'($random(seed)));
		// Abort a slow memory read by reset
		rdy = 1'b0;
		q_req.push_back({1'b0, SPACE_MEM, 22'h2AAAAA, 16'h0, 2'b11});
		fork
			i_car.xfer(SPACE_MEM, 1'b1, 22'h2AAAAA, 16'h0, 2'b00, ok);
			begin
				repeat (12) @(negedge clk);
				arst_n = 1'b0;
				@(negedge clk);
				cmp(43'h5, {40'h0, ack_n, oe, blk});
			end
		join
		cmp(43'h0, {42'h0, ok});
		$display("test reset abort done");
		@(negedge clk);
		arst_n = 1'b1;
		rdy = 1'b1;
		run(SPACE_IO, 1'b1, 22'h00002A, 16'h0, 2'b00);
		tally_and_finish();
	end
endmodule
`default_nettype wire
